// ==== core/lcd_display_control_regs.vh ====
// Purpose: register offsets, fields, reset values of display control group
// Assumes: byte-wide register port at the documented direct addresses
// Notes:   included by the design files only
`ifndef LCD_DISPLAY_CONTROL_REGS_VH
`define LCD_DISPLAY_CONTROL_REGS_VH
`define ADDR_DISPLAY_ON_CONTROL   16'h8009
`define ADDR_BLOCK_ATTRIBUTES     16'h800a
`define ADDR_BLOCK1_START_LOW     16'h800b
`define ADDR_BLOCK1_START_HIGH    16'h800c
`define RESET_BYTE                8'h00
`define DISPLAY_ENABLE_BIT        0
`define ATTR_BLOCK3_HI            7
`define ATTR_BLOCK3_LO            6
`define ATTR_BLOCK2_HI            5
`define ATTR_BLOCK2_LO            4
`define ATTR_BLOCK1_HI            3
`define ATTR_BLOCK1_LO            2
`define ATTR_CURSOR_HI            1
`define ATTR_CURSOR_LO            0
`define ATTR_BLANK                2'h0
`define ATTR_STEADY               2'h1
`define ATTR_FLASH_SLOW           2'h2
`define ATTR_FLASH_FAST           2'h3
`define FRAME_COUNT_WIDTH         6
`define FLASH_DIV_SLOW_BIT        4
`define FLASH_DIV_FAST_BIT        1
`define CURSOR_SLOW_PERIOD        6'h1f
`define CURSOR_SLOW_ON_LIMIT      6'h16
`define CURSOR_FAST_ON_LIMIT      6'h2c
`define SCROLL_FIRST_OFFSET       8'h0b
`define SCROLL_LAST_OFFSET        8'h14
`define DISPLAY_SWITCH_PARAM      8'h0a
`define ADDR_PAGE                 8'h80
`define SEL_NONE                  4'h0
`define SEL_DISPLAY_ON            4'h1
`define SEL_ATTRIBUTES            4'h2
`define SEL_START_LOW             4'h4
`define SEL_START_HIGH            4'h8
`define SEL_BIT_DISPLAY_ON        0
`define SEL_BIT_ATTRIBUTES        1
`define SEL_BIT_START_LOW         2
`define SEL_BIT_START_HIGH        3
`endif

// ==== core/flash_phase_gen.v ====
// Purpose: blink phases derived from a free-running frame counter
// Assumes: frame_tick is a one-cycle pulse at each frame boundary
// Notes:   phases change only on a frame tick
`timescale 1ns/100ps
`include "lcd_display_control_regs.vh"
module flash_phase_gen (
	input  wire clk,
	input  wire rst_n,
	input  wire frame_tick,
	output reg  block_fast_on,
	output reg  block_slow_on,
	output reg  cursor_slow_on,
	output reg  cursor_fast_on
);
	reg [`FRAME_COUNT_WIDTH-1:0] frame_count_r;
	wire [`FRAME_COUNT_WIDTH-1:0] frame_count_nxt;

	assign frame_count_nxt = frame_count_r + 6'h01;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_count_r  <= 6'h00;
			block_fast_on  <= 1'b0;
			block_slow_on  <= 1'b0;
			cursor_slow_on <= 1'b0;
			cursor_fast_on <= 1'b0;
		end else if (frame_tick) begin
			frame_count_r <= frame_count_nxt;
			// Half-duty square waves: /4 and /32 of frame rate
			block_fast_on <= ~frame_count_nxt[`FLASH_DIV_FAST_BIT];
			block_slow_on <= ~frame_count_nxt[`FLASH_DIV_SLOW_BIT];
			// 70 percent on: 22 of 32 frames, 44 of 64 frames
			cursor_slow_on <= ((frame_count_nxt & `CURSOR_SLOW_PERIOD)
				< `CURSOR_SLOW_ON_LIMIT);
			cursor_fast_on <= (frame_count_nxt < `CURSOR_FAST_ON_LIMIT);
		end
	end
endmodule // flash_phase_gen

// ==== core/lcd_display_control_regs.v ====
// Purpose: display enable, block/cursor attributes, block 1 start address
// Assumes: host byte port at direct addresses; strobes are synchronous
// Notes:   indirect command parameter loads use the same write path
//
// Contract
// - Enable bit 0 low turns all LCD output off, high turns it on.
// - Display off blanks everything regardless of block and cursor attributes.
// - Bits 7-6 block 3: blank, steady, flash /32, flash /4.
// - Bits 5-4 block 2, and block 4 too in dual panel mode.
// - Bits 3-2 block 1 with the same four-way encoding.
// - Bits 1-0 cursor: blank, steady, flash /32, flash /64.
// - Flashing cursor shows 70 percent, hides 30 percent of each period.
// - Memory write with cursor disabled re-enables it and advances it; here any register write in the same cycle blocks the re-enable.
// - Memory read advances cursor but does not re-enable it.
// - Block 1 start address is 16 bits, low at 0Bh, high at 0Ch.
// - Display switch command loads attribute register contents as parameters.
// - Scroll command sends offsets 0Bh to 14h as its parameters.
// - After reset all these registers read zero and are read/write.
// - Low byte first; start address changes only when high byte written.
// - Entering power save clears the display enable bit.
`timescale 1ns/100ps
`include "lcd_display_control_regs.vh"
module lcd_display_control_regs (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [15:0] reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire        cmd_param_wr,
	input  wire [7:0]  cmd_param_offset,
	input  wire        power_save_enter,
	input  wire        dual_panel,
	input  wire        frame_tick,
	input  wire        mem_write,
	input  wire        mem_read,
	output reg  [7:0]  reg_rdata,
	output reg         display_on,
	output reg         block1_visible,
	output reg         block2_visible,
	output reg         block3_visible,
	output reg         block4_visible,
	output reg         cursor_visible,
	output reg         cursor_advance,
	output reg  [15:0] block1_start_address
);
	reg        display_on_control_r;
	reg [7:0]  block_and_cursor_attributes_r;
	reg [7:0]  block1_start_addr_low_r;
	reg [7:0]  block1_start_addr_high_r;
	reg [7:0]  read_mux;
	reg [15:0] wr_target;

	wire       block_fast_on;
	wire       block_slow_on;
	wire       cursor_slow_on;
	wire       cursor_fast_on;
	wire       wr_any;
	wire [3:0] wr_sel;
	wire [3:0] rd_sel;
	wire       cursor_blank;
	wire       cursor_revive;
	wire       block1_visible_nxt;
	wire       block2_visible_nxt;
	wire       block3_visible_nxt;
	wire       block4_visible_nxt;
	wire       cursor_visible_nxt;

	// Shared by block attribute decoding
	function attr_visible;
		input [1:0] attr;
		input       fast_on;
		input       slow_on;
		begin
			case (attr)
				`ATTR_BLANK:      attr_visible = 1'b0;
				`ATTR_STEADY:     attr_visible = 1'b1;
				`ATTR_FLASH_SLOW: attr_visible = slow_on;
				`ATTR_FLASH_FAST: attr_visible = fast_on;
				default:          attr_visible = 1'b0;
			endcase
		end
	endfunction

	// One decoder serves writes and reads, so the two maps cannot drift
	function [3:0] reg_select;
		input [15:0] addr;
		begin
			case (addr)
				`ADDR_DISPLAY_ON_CONTROL: reg_select = `SEL_DISPLAY_ON;
				`ADDR_BLOCK_ATTRIBUTES:   reg_select = `SEL_ATTRIBUTES;
				`ADDR_BLOCK1_START_LOW:   reg_select = `SEL_START_LOW;
				`ADDR_BLOCK1_START_HIGH:  reg_select = `SEL_START_HIGH;
				default:                  reg_select = `SEL_NONE;
			endcase
		end
	endfunction

	// Phases run on every frame whether or not anything is shown
	flash_phase_gen u_flash (
		.clk            (clk),
		.rst_n          (rst_n),
		.frame_tick     (frame_tick),
		.block_fast_on  (block_fast_on),
		.block_slow_on  (block_slow_on),
		.cursor_slow_on (cursor_slow_on),
		.cursor_fast_on (cursor_fast_on)
	);

	// Indirect parameters land on the same registers as direct writes
	always @* begin
		wr_target = reg_addr;
		if (cmd_param_wr)
			wr_target = {`ADDR_PAGE, cmd_param_offset};
	end
	assign wr_any = reg_wr | cmd_param_wr;
	// Unmapped targets select nothing, so such writes fall away
	assign wr_sel = wr_any ? reg_select(wr_target) : `SEL_NONE;
	assign rd_sel = reg_select(reg_addr);
	assign cursor_blank =
		(block_and_cursor_attributes_r[`ATTR_CURSOR_HI:`ATTR_CURSOR_LO]
		== `ATTR_BLANK);
	// Any register write in the same cycle cancels the cursor revival
	assign cursor_revive = mem_write & ~wr_any & cursor_blank;

	// Every block and the cursor gated by the enable bit
	assign block1_visible_nxt = display_on_control_r & attr_visible(
		block_and_cursor_attributes_r[`ATTR_BLOCK1_HI:`ATTR_BLOCK1_LO],
		block_fast_on, block_slow_on);
	assign block2_visible_nxt = display_on_control_r & attr_visible(
		block_and_cursor_attributes_r[`ATTR_BLOCK2_HI:`ATTR_BLOCK2_LO],
		block_fast_on, block_slow_on);
	assign block3_visible_nxt = display_on_control_r & attr_visible(
		block_and_cursor_attributes_r[`ATTR_BLOCK3_HI:`ATTR_BLOCK3_LO],
		block_fast_on, block_slow_on);
	// Block 4 exists only on a dual panel and has no field of its own
	assign block4_visible_nxt = dual_panel & block2_visible_nxt;
	// Cursor fast setting is the /64 rate, unlike the blocks
	assign cursor_visible_nxt = display_on_control_r & attr_visible(
		block_and_cursor_attributes_r[`ATTR_CURSOR_HI:`ATTR_CURSOR_LO],
		cursor_fast_on, cursor_slow_on);

	// Power save wins over a simultaneous enable write
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			display_on_control_r <= 1'b0;
		end else if (power_save_enter) begin
			display_on_control_r <= 1'b0;
		end else if (wr_sel[`SEL_BIT_DISPLAY_ON]) begin
			display_on_control_r <= reg_wdata[`DISPLAY_ENABLE_BIT];
		end
	end

	// Memory write revives a blanked cursor as steady
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			block_and_cursor_attributes_r <= `RESET_BYTE;
		end else if (wr_sel[`SEL_BIT_ATTRIBUTES]) begin
			block_and_cursor_attributes_r <= reg_wdata;
		end else if (cursor_revive) begin
			block_and_cursor_attributes_r[`ATTR_CURSOR_HI:`ATTR_CURSOR_LO]
				<= `ATTR_STEADY;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			block1_start_addr_low_r <= `RESET_BYTE;
		end else if (wr_sel[`SEL_BIT_START_LOW]) begin
			block1_start_addr_low_r <= reg_wdata;
		end
	end

	// Low byte alone never moves the live address
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			block1_start_addr_high_r <= `RESET_BYTE;
			block1_start_address     <= {`RESET_BYTE, `RESET_BYTE};
		end else if (wr_sel[`SEL_BIT_START_HIGH]) begin
			block1_start_addr_high_r <= reg_wdata;
			block1_start_address     <=
				{reg_wdata, block1_start_addr_low_r};
		end
	end

	// Enable register shows only its one bit, upper bits read zero
	always @* begin
		read_mux = `RESET_BYTE;
		if (rd_sel[`SEL_BIT_DISPLAY_ON])
			read_mux = {7'h00, display_on_control_r};
		if (rd_sel[`SEL_BIT_ATTRIBUTES])
			read_mux = block_and_cursor_attributes_r;
		if (rd_sel[`SEL_BIT_START_LOW])
			read_mux = block1_start_addr_low_r;
		if (rd_sel[`SEL_BIT_START_HIGH])
			read_mux = block1_start_addr_high_r;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata      <= `RESET_BYTE;
			display_on     <= 1'b0;
			block1_visible <= 1'b0;
			block2_visible <= 1'b0;
			block3_visible <= 1'b0;
			block4_visible <= 1'b0;
			cursor_visible <= 1'b0;
			cursor_advance <= 1'b0;
		end else begin
			if (reg_rd)
				reg_rdata <= read_mux;
			display_on <= display_on_control_r;
			block1_visible <= block1_visible_nxt;
			block2_visible <= block2_visible_nxt;
			block3_visible <= block3_visible_nxt;
			block4_visible <= block4_visible_nxt;
			cursor_visible <= cursor_visible_nxt;
			// Every access advances; only writes revive the cursor
			cursor_advance <= mem_write | mem_read;
		end
	end
endmodule // lcd_display_control_regs

// ==== bench/lcd_display_control_regs_chk.sv ====
// Purpose: port timing checks for the display control group
// Assumes: one clock domain, rst_n active low
// Notes:   bound from the testbench top file
`timescale 1ns/100ps
module lcd_display_control_regs_chk (
	input wire        clk,
	input wire        rst_n,
	input wire [15:0] reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire        cmd_param_wr,
	input wire [7:0]  cmd_param_offset,
	input wire        power_save_enter,
	input wire        dual_panel,
	input wire        mem_write,
	input wire        mem_read,
	input wire [7:0]  reg_rdata,
	input wire        display_on,
	input wire        block1_visible,
	input wire        block2_visible,
	input wire        block3_visible,
	input wire        block4_visible,
	input wire        cursor_visible,
	input wire        cursor_advance,
	input wire [15:0] block1_start_address
);
	wire any_vis = block1_visible | block2_visible | block3_visible |
	    block4_visible | cursor_visible;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_off; !display_on |-> !any_vis; endproperty
	a_off: assert property (p_off)
	    else $error("shown while off");
	property p_on; reg_wr && reg_addr == 16'h8009 && !power_save_enter
	    |-> ##2 display_on == $past(reg_wdata[0], 2); endproperty
	a_on: assert property (p_on)
	    else $error("enable not followed");
	property p_ps; power_save_enter |-> ##2 !display_on; endproperty
	a_ps: assert property (p_ps)
	    else $error("power save kept display");
	property p_hi; reg_wr && reg_addr == 16'h800c
	    |=> block1_start_address[15:8] == $past(reg_wdata); endproperty
	a_hi: assert property (p_hi)
	    else $error("high byte not applied");
	property p_hold; !(reg_wr && reg_addr == 16'h800c) &&
	    !(cmd_param_wr && cmd_param_offset == 8'h0c)
	    |=> $stable(block1_start_address); endproperty
	a_hold: assert property (p_hold)
	    else $error("start address moved");
	property p_unm; reg_rd && (reg_addr < 16'h8009 || reg_addr > 16'h800c)
	    |=> reg_rdata == 8'h00; endproperty
	a_unm: assert property (p_unm)
	    else $error("unmapped read not zero");
	property p_adv; 1 |=> cursor_advance == $past(mem_write || mem_read);
	endproperty
	a_adv: assert property (p_adv)
	    else $error("cursor advance wrong");
	property p_dual; 1 |=> block4_visible ==
	    ($past(dual_panel) && block2_visible); endproperty
	a_dual: assert property (p_dual)
	    else $error("block 4 differs");
endmodule // lcd_display_control_regs_chk

// ==== bench/host_cpu_model.sv ====
// Purpose: host side issuing direct and indirect register transfers
// Assumes: strobes launched 1 ns after the rising edge
// Notes:   released data is inverted so a stale byte never looks valid
`timescale 1ns/100ps
module host_cpu_model (
	input  wire        clk,
	input  wire [7:0]  reg_rdata,
	output reg  [15:0] reg_addr,
	output reg  [7:0]  reg_wdata,
	output reg         reg_wr,
	output reg         reg_rd,
	output reg         cmd_param_wr,
	output reg  [7:0]  cmd_param_offset
);
	initial {reg_addr, reg_wdata, reg_wr, reg_rd, cmd_param_wr,
	    cmd_param_offset} = '0;
	task automatic xfer(input [1:0] k, input [15:0] a, input [7:0] d,
	    output [7:0] q);
		@(posedge clk);
		#1;
		{reg_addr, reg_wdata, cmd_param_offset} = {a, d, a[7:0]};
		{reg_wr, reg_rd} = {k == 2'd0, k == 2'd1};
		cmd_param_wr = (k == 2'd2);
		@(posedge clk);
		#1;
		q = reg_rdata;
		{reg_wr, reg_rd, cmd_param_wr} = 3'b000;
		reg_wdata = ~d;
	endtask
endmodule // host_cpu_model

// ==== bench/lcd_display_control_regs_test.sv ====
// Purpose: self-checking run of the display control group
// Assumes: 10 MHz clk, 20-cycle reset
// Notes:   a frame is 4 cycles so one sample lands per frame
`timescale 1ns/100ps
module lcd_display_control_regs_test;
	reg         clk, rst_n, power_save_enter, dual_panel, frame_tick;
	reg         mem_write, mem_read;
	wire [15:0] reg_addr, block1_start_address;
	wire [7:0]  reg_wdata, cmd_param_offset, reg_rdata;
	wire        reg_wr, reg_rd, cmd_param_wr, display_on, cursor_advance;
	wire        block1_visible, block2_visible, block3_visible;
	wire        block4_visible, cursor_visible;
	integer     errors = 0, n_compared = 0, seed = 32'hc686a6be, cyc = 0;
	integer     i;
	reg [7:0]   q, a, lo, hi;
	reg [15:0]  sa = 16'h0000;
	lcd_display_control_regs u_lcd_display_control_regs (.*);
	host_cpu_model u_host_cpu_model (.*);
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			results;
		end
	end
	task check(input [15:0] got, input [15:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task wr(input [1:0] k, input [15:0] ad, input [7:0] d);
		u_host_cpu_model.xfer(k, ad, d, q);
	endtask
	task rd(input [15:0] ad, input [7:0] e);
		u_host_cpu_model.xfer(2'd1, ad, 8'h00, q);
		check(q, e);
	endtask
	function integer on_cnt(input [1:0] m, input cur);
		on_cnt = m == 2'd0 ? 0 : m == 2'd1 ? 64 : cur ? 44 : 32;
	endfunction
	task frames(input [1:0] m);
		integer b, c, d;
		{b, c, d} = 0;
		repeat (64) begin
			@(posedge clk);
			#1 frame_tick = 1;
			@(posedge clk);
			#1 frame_tick = 0;
			repeat (2) @(posedge clk);
			#1;
			b = b + block1_visible;
			c = c + cursor_visible;
			d = d + block2_visible + block3_visible + block4_visible;
		end
		check(b, on_cnt(m, 0));
		check(c, on_cnt(m, 1));
		check(d, 3 * on_cnt(m, 0));
	endtask
	task mem(input w);
		@(posedge clk);
		#1 {mem_write, mem_read} = {w, !w};
		@(posedge clk);
		#1 {mem_write, mem_read} = 2'b00;
		check(cursor_advance, 1);
	endtask
	initial begin
		{power_save_enter, dual_panel, frame_tick, mem_write, mem_read} = 0;
		rst_n = 0;
		repeat (20) @(posedge clk);
		#1 rst_n = 1;
		for (i = 9; i < 13; i++) rd(16'h8000 + i, 8'h00);
		wr(0, 16'h8020, 8'h5a);
		rd(16'h8020, 8'h00);
		for (i = 0; i < 20; i++) begin
			{a, lo, hi} = {$random(seed), $random(seed)};
			wr(i[0] ? 2'd2 : 2'd0, 16'h800a, a);
			rd(16'h800a, a);
			wr(i[0] ? 2'd2 : 2'd0, 16'h800b, lo);
			check(block1_start_address, sa);
			wr(i[0] ? 2'd2 : 2'd0, 16'h800c, hi);
			sa = {hi, lo};
			check(block1_start_address, sa);
			rd(16'h800b, lo);
			rd(16'h800c, hi);
			wr(0, 16'h8009, a);
			rd(16'h8009, {7'h00, a[0]});
		end
		$display("register test done");
		wr(0, 16'h800a, 8'h55);
		wr(0, 16'h8009, 8'h00);
		@(posedge clk);
		#1;
		check({block1_visible, block2_visible, block3_visible,
		    block4_visible, cursor_visible}, 0);
		dual_panel = 1;
		wr(0, 16'h8009, 8'h01);
		repeat (3) @(posedge clk);
		#1 check({block1_visible, block2_visible, block3_visible,
		    block4_visible, cursor_visible}, 16'h1f);
		$display("enable test done");
		for (i = 0; i < 4; i++) begin
			wr(0, 16'h800a, {4{i[1:0]}});
			frames(i[1:0]);
		end
		$display("flash test done");
		wr(0, 16'h800a, 8'h54);
		mem(0);
		rd(16'h800a, 8'h54);
		mem(1);
		rd(16'h800a, 8'h55);
		@(posedge clk);
		#1 power_save_enter = 1;
		@(posedge clk);
		#1 power_save_enter = 0;
		rd(16'h8009, 8'h00);
		$display("cursor and power save test done");
		results;
	end
endmodule // lcd_display_control_regs_test
bind lcd_display_control_regs lcd_display_control_regs_chk
    u_lcd_display_control_regs_chk (.*);
